// ---- core/ftsl_cfg.svh ----
// constants for the fieldbus telegram slave
`ifndef FTSL_CFG_SVH
`define FTSL_CFG_SVH
`define FTSL_CLK_HZ        125000000
`define FTSL_CHAR_BITS     11
`define FTSL_DATA_BITS     8
`define FTSL_START_CHAR    8'h02
`define FTSL_LEN_EXTRA     8'h02
`define FTSL_LEN_SHORT     8'h06
`define FTSL_LEN_LONG      8'h0e
`define FTSL_TEXT_FIXED    8'h0a
`define FTSL_MAX_DATA      8'hfd
`define FTSL_BAUD_MIN      2400
`define FTSL_BAUD_MAX      115200
`define FTSL_ADR_EXT_BIT   7
`define FTSL_ADR_BCAST_BIT 5
`define FTSL_ADDR_MAX      7'h7e
`define FTSL_SHORT_MAX     7'h1f
`endif

// ---- core/ftsl_pkg.sv ----
// types for the fieldbus telegram slave
package ftsl_pkg;
    typedef enum logic [2:0] {RX_IDLE, RX_LEN, RX_ADR, RX_DATA, RX_CHK} ftsl_rx_e;
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_LEN, TX_ADR, TX_DATA, TX_CHK} ftsl_tx_e;
    typedef logic [7:0] ftsl_byte_t;
endpackage

// ---- core/ftsl_top.sv ----
// fieldbus telegram slave: uart, telegram parser, response framer
//
// Functional notes
// - character is start, 8 data, parity, one stop: 11 bit periods
// - parity makes data plus parity bit even in ones
// - bit rate set by a configuration input, 2400 to 115200 baud
// - node address configurable 1 to 126
// - slave transmits only as answer to a master request
// - half duplex: never drive while receiving
// - telegram is start char 02, length, address, data, check byte
// - length equals data bytes plus two
// - text telegrams: length is 10 fixed plus text length
// - short 8-byte, long 16-byte and variable text formats
// - bit7 clear: bit5 broadcast, else bits 0-4 address 1-31
// - bit7 set: bits 0-6 address, zero means broadcast
// - response echoes received address byte unchanged
// - check byte is xor of telegram bytes, seeded with zero
// - process block is 4 bytes, two 16-bit words
// - parameter block is 12 bytes and includes process block
`timescale 1ns/100ps
`include "ftsl_cfg.svh"
module ftsl_top #(
    parameter int CLK_HZ = `FTSL_CLK_HZ
) (
    input  wire logic              mclk,
    input  wire logic              rst_b,
    input  wire logic [16:0]       baud_rate,
    input  wire logic [6:0]        node_addr,
    input  wire logic              rxd,
    output logic                   txd,
    output logic                   tx_oe,
    output logic                   rx_valid,
    input  wire logic              rx_ready,
    output ftsl_pkg::ftsl_byte_t   rx_data,
    output logic                   rx_last,
    output logic                   rx_bcast,
    output logic                   rx_drop,
    input  wire logic              resp_valid,
    output logic                   resp_ready,
    input  wire ftsl_pkg::ftsl_byte_t resp_data,
    input  wire logic              resp_last,
    output logic                   resp_pending,
    output logic                   tx_busy
);
    import ftsl_pkg::*;

    // ------------------------------------------------------------
    // bit timing
    // ------------------------------------------------------------
    logic [16:0] baud_clamped;
    logic [15:0] bit_div;
    always_comb
    begin
        baud_clamped = baud_rate;
        if (baud_rate < 17'(`FTSL_BAUD_MIN))
            baud_clamped = 17'(`FTSL_BAUD_MIN);
        else if (baud_rate > 17'(`FTSL_BAUD_MAX))
            baud_clamped = 17'(`FTSL_BAUD_MAX);
        bit_div = 16'(CLK_HZ / int'(baud_clamped));
    end

    // ------------------------------------------------------------
    // receiver
    // ------------------------------------------------------------
    logic        rxd_q;
    logic        rx_busy_q;
    logic [15:0] rx_cnt_q;
    logic [3:0]  rx_bit_q;
    logic [9:0]  rx_sh_q;
    logic        rc_valid;
    logic [7:0]  rc_byte;
    logic        rc_perr;
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rxd_q     <= 1'b1;
            rx_busy_q <= 1'b0;
            rx_cnt_q  <= 16'h0000;
            rx_bit_q  <= 4'h0;
            rx_sh_q   <= 10'h000;
            rc_valid  <= 1'b0;
            rc_byte   <= 8'h00;
            rc_perr   <= 1'b0;
        end
        else
        begin
            rxd_q    <= rxd;
            rc_valid <= 1'b0;
            if (!rx_busy_q)
            begin
                // falling edge only, so a line held low cannot retrigger
                if (rxd_q && !rxd && !tx_oe)
                begin
                    rx_busy_q <= 1'b1;
                    rx_cnt_q  <= {1'b0, bit_div[15:1]};
                    rx_bit_q  <= 4'h0;
                end
            end
            else if (rx_cnt_q != 16'h0000)
                rx_cnt_q <= rx_cnt_q - 16'h0001;
            else
            begin
                rx_cnt_q <= bit_div - 16'h0001;
                rx_bit_q <= rx_bit_q + 4'h1;
                if (rx_bit_q == 4'h0 && rxd)
                    rx_busy_q <= 1'b0; // glitch, not a start bit
                else if (rx_bit_q == 4'(`FTSL_CHAR_BITS - 1))
                begin
                    rx_busy_q <= 1'b0;
                    rc_valid  <= 1'b1;
                    rc_byte   <= rx_sh_q[8:1];
                    // parity over data plus parity bit must be even, stop high
                    rc_perr   <= (^rx_sh_q[9:1]) | !rxd;
                end
                else if (rx_bit_q != 4'h0)
                    rx_sh_q <= {rxd, rx_sh_q[9:1]};
            end
        end
    end

    // ------------------------------------------------------------
    // telegram parser
    // ------------------------------------------------------------
    ftsl_rx_e    rs_q;
    logic [7:0]  len_q;
    logic [7:0]  left_q;
    logic [7:0]  xor_q;
    logic [7:0]  adr_q;
    logic        mine_q;
    logic        bcast_q;
    logic        bad_q;
    logic        adr_mine;
    logic        adr_bcast;
    always_comb
    begin
        if (rc_byte[`FTSL_ADR_EXT_BIT])
        begin
            adr_bcast = (rc_byte[6:0] == 7'h00);
            adr_mine  = (rc_byte[6:0] == node_addr) && (node_addr <= `FTSL_ADDR_MAX);
        end
        else
        begin
            adr_bcast = rc_byte[`FTSL_ADR_BCAST_BIT];
            adr_mine  = !adr_bcast && (node_addr <= `FTSL_SHORT_MAX)
                        && ({2'b00, rc_byte[4:0]} == node_addr);
        end
    end

    // two-entry buffer toward the user
    logic [8:0]  buf_q [2];
    logic [1:0]  buf_cnt_q;
    logic        buf_wr;
    logic        buf_rd;
    logic        buf_full;
    logic        rd_ptr_q;
    logic        wr_ptr_q;
    logic        mine_q_or_b;
    assign buf_full   = buf_cnt_q == 2'd2;
    assign rx_valid   = buf_cnt_q != 2'd0;
    assign buf_rd     = rx_valid && rx_ready;
    assign rx_data    = buf_q[rd_ptr_q][7:0];
    assign rx_last    = buf_q[rd_ptr_q][8];
    assign mine_q_or_b = mine_q | bcast_q;
    assign buf_wr     = rc_valid && rs_q == RX_DATA && mine_q_or_b && !buf_full;

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            buf_q[0]  <= 9'h000;
            buf_q[1]  <= 9'h000;
            buf_cnt_q <= 2'd0;
            rd_ptr_q  <= 1'b0;
            wr_ptr_q  <= 1'b0;
        end
        else
        begin
            if (buf_wr)
            begin
                buf_q[wr_ptr_q] <= {left_q == 8'h02, rc_byte};
                wr_ptr_q        <= !wr_ptr_q;
            end
            if (buf_rd)
                rd_ptr_q <= !rd_ptr_q;
            buf_cnt_q <= buf_cnt_q + {1'b0, buf_wr} - {1'b0, buf_rd};
        end
    end

    logic tele_ok;
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rs_q     <= RX_IDLE;
            len_q    <= 8'h00;
            left_q   <= 8'h00;
            xor_q    <= 8'h00;
            adr_q    <= 8'h00;
            mine_q   <= 1'b0;
            bcast_q  <= 1'b0;
            bad_q    <= 1'b0;
            tele_ok  <= 1'b0;
            rx_bcast <= 1'b0;
            rx_drop  <= 1'b0;
        end
        else
        begin
            tele_ok  <= 1'b0;
            rx_bcast <= 1'b0;
            rx_drop  <= 1'b0;
            if (rc_valid)
            begin
                xor_q <= xor_q ^ rc_byte;
                if (rc_perr || (rc_valid && rs_q == RX_DATA && buf_full))
                    bad_q <= 1'b1;
                case (rs_q)
                    RX_IDLE:
                    begin
                        xor_q <= 8'h00 ^ rc_byte;
                        bad_q <= rc_perr;
                        if (rc_byte == `FTSL_START_CHAR && !rc_perr)
                            rs_q <= RX_LEN;
                    end
                    RX_LEN:
                    begin
                        len_q  <= rc_byte;
                        left_q <= rc_byte;
                        // 6 short, 14 long, 10 plus text length otherwise
                        if (rc_byte < `FTSL_LEN_EXTRA || rc_byte > `FTSL_MAX_DATA)
                            rs_q <= RX_IDLE;
                        else
                            rs_q <= RX_ADR;
                    end
                    RX_ADR:
                    begin
                        adr_q   <= rc_byte;
                        mine_q  <= adr_mine;
                        bcast_q <= adr_bcast;
                        left_q  <= left_q - 8'h01;
                        rs_q    <= (left_q == 8'h02) ? RX_CHK : RX_DATA;
                    end
                    RX_DATA:
                    begin
                        // data bytes: 4 process, 12 with parameter channel
                        left_q <= left_q - 8'h01;
                        if (left_q == 8'h02)
                            rs_q <= RX_CHK;
                    end
                    RX_CHK:
                    begin
                        rs_q <= RX_IDLE;
                        if ((xor_q ^ rc_byte) == 8'h00 && !bad_q && !rc_perr)
                        begin
                            tele_ok  <= mine_q;
                            rx_bcast <= bcast_q;
                        end
                        else
                            rx_drop <= mine_q | bcast_q;
                    end
                    default: rs_q <= RX_IDLE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // response framer and transmitter
    // ------------------------------------------------------------
    ftsl_tx_e    ts_q;
    logic        pend_q;
    logic [7:0]  tx_len_q;
    logic [7:0]  tx_xor_q;
    logic [15:0] tx_cnt_q;
    logic [3:0]  tx_bit_q;
    logic [10:0] tx_sh_q;
    logic        tx_act_q;
    logic        load;
    logic [7:0]  load_byte;
    logic        take_resp;
    logic        load_q;
    assign tx_busy      = ts_q != TX_IDLE;
    assign resp_pending = pend_q;
    assign resp_ready   = ts_q == TX_DATA && !tx_act_q && !load_q;
    assign take_resp    = resp_valid && resp_ready;

    always_comb
    begin
        load      = 1'b0;
        load_byte = 8'h00;
        if (!tx_act_q && !load_q)
        begin
            case (ts_q)
                TX_START: begin load = 1'b1; load_byte = `FTSL_START_CHAR; end
                TX_LEN:   begin load = 1'b1; load_byte = tx_len_q; end
                TX_ADR:   begin load = 1'b1; load_byte = adr_q; end
                TX_DATA:  begin load = take_resp; load_byte = resp_data; end
                TX_CHK:   begin load = 1'b1; load_byte = tx_xor_q; end
                default:  begin load = 1'b0; load_byte = 8'h00; end
            endcase
        end
    end

    // response length must be known up front; the user answers with the
    // same block type it was addressed with, so the request length is reused
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ts_q     <= TX_IDLE;
            pend_q   <= 1'b0;
            tx_len_q <= 8'h00;
            tx_xor_q <= 8'h00;
            load_q   <= 1'b0;
        end
        else
        begin
            load_q <= load;
            if (load)
                tx_xor_q <= tx_xor_q ^ load_byte;
            case (ts_q)
                TX_IDLE:
                begin
                    tx_xor_q <= 8'h00;
                    if (pend_q && resp_valid && rs_q == RX_IDLE && !rx_busy_q)
                    begin
                        pend_q <= 1'b0;
                        ts_q   <= TX_START;
                    end
                    // set wins: a request finishing as the owed answer starts stays owed
                    if (tele_ok)
                    begin
                        pend_q   <= 1'b1;
                        tx_len_q <= len_q;
                    end
                end
                TX_START: if (load) ts_q <= TX_LEN;
                TX_LEN:   if (load) ts_q <= TX_ADR;
                TX_ADR:   if (load) ts_q <= (tx_len_q == 8'h02) ? TX_CHK : TX_DATA;
                TX_DATA:  if (take_resp && resp_last) ts_q <= TX_CHK;
                TX_CHK:   if (load) ts_q <= TX_IDLE;
                default:  ts_q <= TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tx_act_q <= 1'b0;
            tx_cnt_q <= 16'h0000;
            tx_bit_q <= 4'h0;
            tx_sh_q  <= 11'h7ff;
            txd      <= 1'b1;
            tx_oe    <= 1'b0;
        end
        else if (load)
        begin
            // stop, even parity, data lsb first, start
            tx_sh_q  <= {1'b1, ^load_byte, load_byte, 1'b0};
            tx_act_q <= 1'b1;
            tx_bit_q <= 4'h0;
            tx_cnt_q <= 16'h0000;
            tx_oe    <= 1'b1;
        end
        else if (tx_act_q)
        begin
            if (tx_cnt_q == 16'h0000)
            begin
                if (tx_bit_q == 4'(`FTSL_CHAR_BITS))
                begin
                    tx_act_q <= 1'b0;
                    tx_oe    <= ts_q != TX_IDLE;
                end
                else
                begin
                    txd      <= tx_sh_q[0];
                    tx_sh_q  <= {1'b1, tx_sh_q[10:1]};
                    tx_bit_q <= tx_bit_q + 4'h1;
                    tx_cnt_q <= bit_div - 16'h0001;
                end
            end
            else
                tx_cnt_q <= tx_cnt_q - 16'h0001;
        end
        else if (ts_q == TX_IDLE)
        begin
            tx_oe <= 1'b0;
            txd   <= 1'b1;
        end
    end
endmodule

// ---- verification/ftsl_monitor.sv ----
// port checker for the fieldbus telegram slave
`timescale 1ns/100ps
module ftsl_monitor (
    input wire logic                 mclk,
    input wire logic                 rst_b,
    input wire logic                 txd,
    input wire logic                 tx_oe,
    input wire logic                 rx_valid,
    input wire logic                 rx_ready,
    input wire ftsl_pkg::ftsl_byte_t rx_data,
    input wire logic                 rx_last,
    input wire logic                 rx_bcast,
    input wire logic                 rx_drop,
    input wire logic                 resp_valid,
    input wire logic                 resp_ready,
    input wire logic                 resp_pending,
    input wire logic                 tx_busy
);
    import ftsl_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    sequence drive_on_s;
        tx_oe [*8];
    endsequence
    sequence quiet_s;
        !resp_pending [*3];
    endsequence
    idle_high_a: assert property (!tx_oe |-> txd)
        else $error("txd low while released");
    no_unsolicited_a: assert property ($rose(tx_busy) |-> $past(resp_pending))
        else $error("response without request");
    drive_hold_a: assert property ($rose(tx_oe) |-> drive_on_s)
        else $error("driver dropped inside a character");
    bcast_quiet_a: assert property (rx_bcast |-> quiet_s)
        else $error("broadcast answered");
    drop_quiet_a: assert property (rx_drop |-> quiet_s)
        else $error("rejected telegram answered");
    pulse_one_a: assert property (rx_bcast || rx_drop |=> !rx_bcast && !rx_drop)
        else $error("status pulse too long");
    pulse_excl_a: assert property (!(rx_bcast && rx_drop))
        else $error("broadcast and drop together");
    take_framed_a: assert property (resp_ready |-> tx_busy && tx_oe)
        else $error("response taken outside framing");
    pend_hold_a: assert property (resp_pending && !resp_valid |=> resp_pending)
        else $error("owed response lost");
    rx_hold_a: assert property (rx_valid && !rx_ready && !rx_drop |=>
        rx_valid && $stable(rx_data) && $stable(rx_last))
        else $error("stalled byte changed");
endmodule
bind ftsl_top ftsl_monitor mon (.mclk, .rst_b, .txd, .tx_oe, .rx_valid, .rx_ready,
    .rx_data, .rx_last, .rx_bcast, .rx_drop, .resp_valid, .resp_ready, .resp_pending,
    .tx_busy);

// ---- verification/ftsl_master_model.sv ----
// bus master model: sends requests, decodes slave answers
`timescale 1ns/100ps
module ftsl_master_model (
    input  wire logic mclk,
    input  wire logic txd,
    input  wire logic tx_oe,
    output logic      rxd
);
    logic [7:0]  got_q[$];
    logic [10:0] sf, fr;
    logic        drv;
    int          div = 8;
    int          gap;
    int          bad_cnt;

    // sole master; bias holds the line high when nobody drives
    assign rxd = tx_oe ? txd : drv;

    task automatic send(input logic [7:0] b, input logic perr);
        sf = {1'b1, ^b ^ perr, b, 1'b0};
        for (int i = 0; i < 11 + gap; i++)
        begin
            @(negedge mclk);
            drv = i < 11 ? sf[i] : 1'b1;
            repeat (div - 1) @(negedge mclk);
        end
    endtask

    initial
    begin
        drv = 1'b1;
        forever
        begin
            @(negedge mclk);
            if (tx_oe === 1'b1 && txd === 1'b0)
            begin
                repeat (div / 2) @(negedge mclk);
                for (int i = 0; i < 11; i++)
                begin
                    if (i > 0)
                        repeat (div) @(negedge mclk);
                    fr[i] = txd;
                end
                if (fr[0] !== 1'b0 || fr[10] !== 1'b1 || ^fr[9:1] !== 1'b0)
                    bad_cnt++;
                got_q.push_back(fr[8:1]);
            end
        end
    end
endmodule

// ---- verification/ftsl_top_tb.sv ----
// self-checking bench for the fieldbus telegram slave
`timescale 1ns/100ps
module ftsl_top_tb;
    import ftsl_pkg::*;
    logic        mclk, rst_b, rxd, txd, tx_oe, rx_valid, rx_ready, rx_last;
    logic        rx_bcast, rx_drop, resp_valid, resp_ready, resp_last, resp_pending, tx_busy;
    logic [16:0] baud_rate;
    logic [6:0]  node_addr;
    ftsl_byte_t  rx_data, resp_data;
    logic [8:0]  rxq[$];
    int          num_errors, total_checks, n_bc, n_dr, n_pd, cyc;

    // bit divider of 8 at 115200 keeps the run short
    ftsl_top #(.CLK_HZ(921600)) uut (.mclk, .rst_b, .baud_rate, .node_addr, .rxd, .txd,
        .tx_oe, .rx_valid, .rx_ready, .rx_data, .rx_last, .rx_bcast, .rx_drop, .resp_valid,
        .resp_ready, .resp_data, .resp_last, .resp_pending, .tx_busy);
    ftsl_master_model m (.mclk, .txd, .tx_oe, .rxd);

    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // sampled mid-cycle, where the registered outputs have settled
    always @(negedge mclk)
    begin
        cyc++;
        if (rx_valid && rx_ready)
            rxq.push_back({rx_last, rx_data});
        n_bc += int'(rx_bcast);
        n_dr += int'(rx_drop);
        n_pd += int'(resp_pending);
        if (cyc == 90000)
        begin
            num_errors++;
            report_and_stop();
        end
    end

    task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
        total_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // --------------------------------------------------
    // one request, its delivery, and the owed answer
    // --------------------------------------------------
    task automatic run(input logic [7:0] adr, input int n, input logic [7:0] cerr,
                       input logic perr, input int bc, input int dr, input int nx);
        logic [7:0] t[$];
        logic [7:0] c;
        logic       p;
        int         k;
        t = {8'h02, 8'(n + 2), adr};
        for (int i = 0; i < n; i++)
            t.push_back(8'(8'h30 + i));
        c = 8'h00;
        foreach (t[i])
            c ^= t[i];
        t.push_back(c ^ cerr);
        p = bc == 0 && dr == 0 && nx == n;
        rxq.delete();
        {n_bc, n_dr, n_pd} = 96'h0;
        foreach (t[i])
            m.send(t[i], perr && i == n + 3);
        repeat (40) @(negedge mclk);
        chk("rx count", 9'(nx), 9'(rxq.size()));
        for (int i = 0; i < nx; i++)
            chk("rx byte", {i == n - 1, t[i + 3]}, rxq[i]);
        chk("bcast", 9'(bc), 9'(n_bc));
        chk("drop", 9'(dr), 9'(n_dr));
        chk("owed", {8'h0, p}, 9'(n_pd > 0));
        if (p)
        begin
            for (int i = 0; i < n; i++)
            begin
                t[i + 3] = 8'(8'hc0 + i);
                @(negedge mclk);
                resp_valid = 1'b1;
                resp_data = t[i + 3];
                resp_last = (i == n - 1);
                k = 0;
                #1;
                while (resp_ready !== 1'b1 && k < 30000)
                begin
                    @(negedge mclk);
                    #1;
                    k++;
                end
                if (k == 30000)
                    num_errors++;
                @(posedge mclk);
            end
            @(negedge mclk);
            resp_valid = 1'b0;
            c = 8'h00;
            for (int i = 0; i < n + 3; i++)
                c ^= t[i];
            t[n + 3] = c;
            k = 0;
            while (m.got_q.size() < n + 4 && k < 40000)
            begin
                @(negedge mclk);
                k++;
            end
            if (k == 40000)
                num_errors++;
            repeat (20) @(negedge mclk);
            foreach (t[i])
                chk("tx byte", {1'b0, t[i]}, {1'b0, m.got_q[i]});
            chk("line faults", 9'h0, 9'(m.bad_cnt));
            chk("tx released", 9'h0, {8'h0, tx_oe});
        end
        m.got_q.delete();
    endtask

    initial
    begin
        rst_b = 1'b0;
        baud_rate = 17'h1c200;
        node_addr = 7'h05;
        rx_ready = 1'b1;
        resp_valid = 1'b0;
        resp_data = 8'h00;
        resp_last = 1'b0;
        repeat (2) @(negedge mclk);
        chk("txd idle", 9'h1, {8'h0, txd});
        chk("oe idle", 9'h0, {8'h0, tx_oe});
        rst_b = 1'b1;
        repeat (4) @(negedge mclk);
        run(8'h85, 4, 8'h00, 1'b0, 0, 0, 4);
        run(8'h45, 12, 8'h00, 1'b0, 0, 0, 12);
        run(8'h85, 10, 8'h00, 1'b0, 0, 0, 10);
        run(8'h3f, 4, 8'h00, 1'b0, 1, 0, 4);
        run(8'h80, 4, 8'h00, 1'b0, 1, 0, 4);
        run(8'h86, 4, 8'h00, 1'b0, 0, 0, 0);
        run(8'h06, 4, 8'h00, 1'b0, 0, 0, 0);
        run(8'h85, 4, 8'h01, 1'b0, 0, 1, 4);
        run(8'h85, 4, 8'h00, 1'b1, 0, 1, 4);
        // receiver stalls: the two-entry buffer overflows
        rx_ready = 1'b0;
        run(8'h85, 4, 8'h00, 1'b0, 0, 1, 0);
        rx_ready = 1'b1;
        repeat (40) @(negedge mclk);
        baud_rate = 17'h0e100;
        m.div = 16;
        m.gap = 3;
        run(8'h85, 4, 8'h00, 1'b0, 0, 0, 4);
        report_and_stop();
    end
endmodule
